/* File: ics_slave.v */
// Two-wire command slave: bus framing, opcode decode, RAM and store access
`timescale 1ns/1ps
`default_nettype none
`include "ics_consts.vh"
// Notes on behaviour
// - Answer only seven-bit address 0001111
// - Header low bit zero means read
// - Bytes after header use four-wire command set
// - Bus active only while strap is high
// - Lines idle high; sample on clock rise
// - 0x00 writes RAM, 0x40 reads RAM
// - 0xF0 full reset, 0xC0 init reset
// - 0xCC continuous, 0xCE single conversion
// - 0x9E watchdog off, 0x9F on
// - 0x86/87 reference, 0x90/91 store enable
// - User store holds 128 bytes
// - 0xA0 returns dummy zero then data
// - 0xA1 writes one store byte
// - 0xA2 clears one byte, data ignored
// - 0xA4 clears whole store
// - 0xA6 reads, 0xA7 writes program memory
// - 0xA8/A9 access, 0xAC/AD programming enable
// - Copy result 244 to 0 without program
module ics_slave (
   input wire clock_i,
   input wire sys_rst_i,
   input wire bus_clock_pin_i,
   input wire bus_data_pin_i,
   output wire bus_data_pin_o,
   output wire bus_data_pin_oe_o,
   input wire if_sel_strap_i,
   output wire bus_owns_pins_o,
   input wire user_prog_present_i,
   input wire result_valid_i,
   input wire [23:0] main_bridge_result_i,
   output reg power_reset_o,
   output reg init_reset_o,
   output reg start_continuous_o,
   output reg begin_single_conversion_o,
   output reg watchdog_en_o,
   output reg ee_ref_on_o,
   output reg ee_access_en_o,
   output reg otp_access_en_o,
   output reg otp_prog_en_o,
   output reg otp_wr_o,
   output reg [15:0] otp_addr_o,
   output reg [7:0] otp_wdata_o,
   input wire [7:0] otp_rdata_i
);
   localparam S_IDLE = 7'h01;
   localparam S_HDR = 7'h02;
   localparam S_HACK = 7'h04;
   localparam S_RX = 7'h08;
   localparam S_RACK = 7'h10;
   localparam S_TX = 7'h20;
   localparam S_TACK = 7'h40;

   wire [2:0] pin_q;
   wire [2:0] pin_rise;
   wire [2:0] pin_fall;
   wire scl;
   wire sda;
   wire sel;
   wire scl_rise;
   wire scl_fall;
   wire start_cond;
   wire stop_cond;
   wire [7:0] rx_byte;
   wire [7:0] ee_rdata;

   reg [6:0] state;
   reg [3:0] bitcnt;
   reg [7:0] shreg;
   reg rd;
   reg oe;
   reg first;
   reg [7:0] op;
   reg [2:0] idx;
   reg [7:0] addr;
   reg [7:0] alo;
   reg [15:0] word;
   reg [1:0] tx_idx;
   reg ee_we;
   reg ee_erase_all;
   reg [7:0] ee_wdata;
   reg [23:0] ram [0:`ICS_RAM_DEPTH-1];
   reg ram_we;
   reg [23:0] ram_wdata;
   reg [7:0] txb;

   // Opcode match, used across the decoder
   function is_op;
      input [7:0] a;
      input [7:0] b;
      begin
         is_op = (a == b);
      end
   endfunction

   // Pins pass two flip-flops before use
   ics_sync #(
      .W(3)
   ) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .d_i({if_sel_strap_i, bus_data_pin_i, bus_clock_pin_i}),
      .q_o(pin_q),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   assign scl = pin_q[0];
   assign sda = pin_q[1];
   assign sel = pin_q[2];
   assign scl_rise = pin_rise[0];
   assign scl_fall = pin_fall[0];
   assign start_cond = pin_fall[1] & scl;
   assign stop_cond = pin_rise[1] & scl;
   assign rx_byte = {shreg[6:0], sda};

   // Byte-wide user store
   ics_ueeprom u_ee (
      .clock_i(clock_i),
      .we_i(ee_we),
      .erase_all_i(ee_erase_all),
      .addr_i(addr[6:0]),
      .wdata_i(ee_wdata),
      .rdata_o(ee_rdata)
   );

   // Byte the master clocks out next
   always @* begin
      txb = `ICS_EE_DUMMY;
      if (is_op(op, `ICS_OP_RAM_RD)) begin
         case (tx_idx)
            2'h0: txb = ram[addr][23:16];
            2'h1: txb = ram[addr][15:8];
            default: txb = ram[addr][7:0];
         endcase
      end else if (is_op(op, `ICS_OP_EE_RD)) begin
         txb = (tx_idx == 2'h0) ? `ICS_EE_DUMMY : ee_rdata;
      end else if (is_op(op, `ICS_OP_OTP_RD)) begin
         txb = otp_rdata_i;
      end
   end

   // Result copy from the core, and bus writes
   always @(posedge clock_i) begin
      if (result_valid_i) begin
         ram[`ICS_RES_ADDR] <= main_bridge_result_i;
         if (!user_prog_present_i) begin
            ram[`ICS_COPY_ADDR] <= main_bridge_result_i;
         end
      end
      if (ram_we) begin
         ram[addr] <= ram_wdata;
      end
   end

   // Bus framing and command decode
   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= S_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         rd <= 1'b0;
         oe <= 1'b0;
         first <= 1'b0;
         op <= 8'h00;
         idx <= 3'h0;
         addr <= 8'h00;
         alo <= 8'h00;
         word <= 16'h0000;
         tx_idx <= 2'h0;
         ee_we <= 1'b0;
         ee_erase_all <= 1'b0;
         ee_wdata <= 8'h00;
         ram_we <= 1'b0;
         ram_wdata <= 24'h000000;
         power_reset_o <= 1'b0;
         init_reset_o <= 1'b0;
         start_continuous_o <= 1'b0;
         begin_single_conversion_o <= 1'b0;
         watchdog_en_o <= `ICS_RST_WD_EN;
         ee_ref_on_o <= 1'b0;
         ee_access_en_o <= 1'b0;
         otp_access_en_o <= 1'b0;
         otp_prog_en_o <= 1'b0;
         otp_wr_o <= 1'b0;
         otp_addr_o <= 16'h0000;
         otp_wdata_o <= 8'h00;
      end else begin
         power_reset_o <= 1'b0;
         init_reset_o <= 1'b0;
         start_continuous_o <= 1'b0;
         begin_single_conversion_o <= 1'b0;
         otp_wr_o <= 1'b0;
         ee_we <= 1'b0;
         ee_erase_all <= 1'b0;
         if (ram_we) begin
            ram_we <= 1'b0;
            addr <= addr + 8'h01;
         end
         if (!sel) begin
            state <= S_IDLE;
            oe <= 1'b0;
            idx <= 3'h0;
         end else if (stop_cond) begin
            state <= S_IDLE;
            oe <= 1'b0;
            idx <= 3'h0;
         end else if (start_cond) begin
            state <= S_HDR;
            bitcnt <= 4'h0;
            oe <= 1'b0;
         end else begin
            case (state)
               S_HDR: begin
                  if (scl_rise) begin
                     shreg <= rx_byte;
                     bitcnt <= bitcnt + 4'h1;
                     if (bitcnt == `ICS_BITS_PER_BYTE - 4'h1) begin
                        if ({rx_byte[7:1], 1'b1} == `ICS_HDR_WR) begin
                           state <= S_HACK;
                           rd <= (rx_byte[0] == `ICS_DIR_READ);
                           tx_idx <= 2'h0;
                        end else begin
                           state <= S_IDLE;
                        end
                     end
                  end
               end
               S_HACK, S_RACK: begin
                  if (scl_fall) begin
                     if (!oe) begin
                        oe <= 1'b1;
                     end else begin
                        bitcnt <= 4'h0;
                        if (state == S_HACK && rd) begin
                           state <= S_TX;
                           shreg <= txb;
                           oe <= ~txb[7];
                           first <= 1'b0;
                        end else begin
                           state <= S_RX;
                           oe <= 1'b0;
                        end
                     end
                  end
               end
               S_RX: begin
                  if (scl_rise) begin
                     shreg <= rx_byte;
                     bitcnt <= bitcnt + 4'h1;
                     if (bitcnt == `ICS_BITS_PER_BYTE - 4'h1) begin
                        state <= S_RACK;
                        if (idx != 3'h7) begin
                           idx <= idx + 3'h1;
                        end
                        // Same byte meaning as the four-wire port
                        case (idx)
                           3'h0: begin
                              op <= rx_byte;
                              case (rx_byte)
                                 `ICS_OP_PWR_RST: power_reset_o <= 1'b1;
                                 `ICS_OP_INIT_RST: init_reset_o <= 1'b1;
                                 `ICS_OP_START_CONT: start_continuous_o <= 1'b1;
                                 `ICS_OP_START_SINGLE: begin
                                    begin_single_conversion_o <= 1'b1;
                                 end
                                 `ICS_OP_WD_OFF: watchdog_en_o <= 1'b0;
                                 `ICS_OP_WD_ON: watchdog_en_o <= 1'b1;
                                 `ICS_OP_EE_REF_OFF: ee_ref_on_o <= 1'b0;
                                 `ICS_OP_EE_REF_ON: ee_ref_on_o <= 1'b1;
                                 `ICS_OP_EE_EN_OFF: ee_access_en_o <= 1'b0;
                                 `ICS_OP_EE_EN_ON: ee_access_en_o <= 1'b1;
                                 `ICS_OP_OTP_EN_OFF: otp_access_en_o <= 1'b0;
                                 `ICS_OP_OTP_EN_ON: otp_access_en_o <= 1'b1;
                                 `ICS_OP_OTP_PG_OFF: otp_prog_en_o <= 1'b0;
                                 `ICS_OP_OTP_PG_ON: otp_prog_en_o <= 1'b1;
                                 default: ;
                              endcase
                           end
                           3'h1: begin
                              addr <= rx_byte;
                           end
                           3'h2: begin
                              alo <= rx_byte;
                              word[15:8] <= rx_byte;
                              // Store writes and erases need reference and enable on
                              if (ee_ref_on_o && ee_access_en_o) begin
                                 if (is_op(op, `ICS_OP_EE_WR)) begin
                                    ee_we <= 1'b1;
                                    ee_wdata <= rx_byte;
                                 end
                                 if (is_op(op, `ICS_OP_EE_ERASE)) begin
                                    ee_we <= 1'b1;
                                    ee_wdata <= `ICS_EE_ERASED;
                                 end
                                 if (is_op(op, `ICS_OP_EE_BERASE)) begin
                                    ee_erase_all <= 1'b1;
                                 end
                              end
                           end
                           3'h3: begin
                              word[7:0] <= rx_byte;
                              if (is_op(op, `ICS_OP_OTP_WR)) begin
                                 // Programming only with both enables set
                                 if (otp_access_en_o && otp_prog_en_o) begin
                                    otp_wr_o <= 1'b1;
                                 end
                                 otp_addr_o <= {addr, alo};
                                 otp_wdata_o <= rx_byte;
                              end
                           end
                           3'h4: begin
                              if (is_op(op, `ICS_OP_RAM_WR)) begin
                                 ram_we <= 1'b1;
                                 ram_wdata <= {word, rx_byte};
                                 idx <= 3'h2;
                              end
                           end
                           default: ;
                        endcase
                     end
                  end
               end
               S_TX: begin
                  if (scl_rise) begin
                     bitcnt <= bitcnt + 4'h1;
                     if (bitcnt == `ICS_BITS_PER_BYTE - 4'h1) begin
                        state <= S_TACK;
                     end
                  end else if (scl_fall) begin
                     if (first) begin
                        shreg <= txb; // Next byte, index already moved on
                        oe <= ~txb[7];
                        first <= 1'b0;
                     end else begin
                        oe <= ~shreg[6];
                        shreg <= {shreg[6:0], 1'b0};
                     end
                  end
               end
               S_TACK: begin
                  if (scl_fall) begin
                     oe <= 1'b0;
                  end else if (scl_rise) begin
                     if (!sda) begin
                        state <= S_TX;
                        bitcnt <= 4'h0;
                        first <= 1'b1;
                        if (is_op(op, `ICS_OP_RAM_RD)) begin
                           if (tx_idx == `ICS_RAM_WORD_BYTES - 2'h1) begin
                              tx_idx <= 2'h0;
                              addr <= addr + 8'h01;
                           end else begin
                              tx_idx <= tx_idx + 2'h1;
                           end
                        end else if (is_op(op, `ICS_OP_OTP_RD)) begin
                           {addr, alo} <= {addr, alo} + 16'h0001;
                        end else begin
                           tx_idx <= 2'h1;
                        end
                     end else begin
                        state <= S_IDLE;
                     end
                  end
               end
               default: begin
                  state <= S_IDLE;
                  oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain data pin: only ever pulled low
   assign bus_data_pin_o = 1'b0;
   assign bus_data_pin_oe_o = oe & sel;
   assign bus_owns_pins_o = sel;
endmodule // ics_slave
`default_nettype wire

/* File: ics_consts.vh */
// Constants of the two-wire command slave
`ifndef ICS_CONSTS_VH
`define ICS_CONSTS_VH
`define ICS_DEV_ADDR 7'h1f
`define ICS_DIR_READ 1'b0
`define ICS_HDR_WR 8'h1f
`define ICS_OP_RAM_WR 8'h00
`define ICS_OP_RAM_RD 8'h40
`define ICS_OP_PWR_RST 8'hf0
`define ICS_OP_INIT_RST 8'hc0
`define ICS_OP_START_CONT 8'hcc
`define ICS_OP_START_SINGLE 8'hce
`define ICS_OP_WD_OFF 8'h9e
`define ICS_OP_WD_ON 8'h9f
`define ICS_OP_EE_REF_OFF 8'h86
`define ICS_OP_EE_REF_ON 8'h87
`define ICS_OP_EE_EN_OFF 8'h90
`define ICS_OP_EE_EN_ON 8'h91
`define ICS_OP_EE_RD 8'ha0
`define ICS_OP_EE_WR 8'ha1
`define ICS_OP_EE_ERASE 8'ha2
`define ICS_OP_EE_BERASE 8'ha4
`define ICS_OP_OTP_RD 8'ha6
`define ICS_OP_OTP_WR 8'ha7
`define ICS_OP_OTP_EN_OFF 8'ha8
`define ICS_OP_OTP_EN_ON 8'ha9
`define ICS_OP_OTP_PG_OFF 8'hac
`define ICS_OP_OTP_PG_ON 8'had
`define ICS_EE_DEPTH 128
`define ICS_EE_ERASED 8'h00
`define ICS_EE_DUMMY 8'h00
`define ICS_RAM_DEPTH 256
`define ICS_RES_ADDR 8'hf4
`define ICS_COPY_ADDR 8'h00
`define ICS_RST_WD_EN 1'b1
`define ICS_BITS_PER_BYTE 4'h8
`define ICS_RAM_WORD_BYTES 2'h3
`endif

/* File: ics_sync.v */
// Two-stage synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module ics_sync #(
   parameter W = 3
) (
   input wire clock_i,
   input wire sys_rst_i,
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o,
   output wire [W-1:0] rise_o,
   output wire [W-1:0] fall_o
);
   reg [W-1:0] meta;
   reg [W-1:0] stable;
   reg [W-1:0] prev;

   // Pin lines idle high
   always @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta <= {W{1'b1}};
         stable <= {W{1'b1}};
         prev <= {W{1'b1}};
      end else begin
         meta <= d_i;
         stable <= meta;
         prev <= stable;
      end
   end

   assign q_o = stable;
   assign rise_o = stable & ~prev;
   assign fall_o = ~stable & prev;
endmodule // ics_sync
`default_nettype wire

/* File: ics_ueeprom.v */
// User byte store, 128 bytes, with single and block erase
`timescale 1ns/1ps
`default_nettype none
`include "ics_consts.vh"
module ics_ueeprom (
   input wire clock_i,
   input wire we_i,
   input wire erase_all_i,
   input wire [6:0] addr_i,
   input wire [7:0] wdata_i,
   output wire [7:0] rdata_o
);
   reg [7:0] mem [0:`ICS_EE_DEPTH-1];
   integer i;

   // Byte write or whole-array erase
   always @(posedge clock_i) begin
      if (erase_all_i) begin
         for (i = 0; i < `ICS_EE_DEPTH; i = i + 1) begin
            mem[i] <= `ICS_EE_ERASED;
         end
      end else if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem[addr_i];
endmodule // ics_ueeprom
`default_nettype wire

/* File: ics_slave_assertions.sv */
// Checker for the port behaviour of the two-wire command slave
`timescale 1ns/1ps
`default_nettype none
module ics_slave_assertions (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic bus_clock_pin_i,
   input wire logic bus_data_pin_o,
   input wire logic bus_data_pin_oe_o,
   input wire logic bus_owns_pins_o,
   input wire logic watchdog_en_o,
   input wire logic power_reset_o,
   input wire logic init_reset_o,
   input wire logic start_continuous_o,
   input wire logic begin_single_conversion_o,
   input wire logic otp_wr_o,
   input wire logic otp_access_en_o,
   input wire logic otp_prog_en_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   // Open-drain data pin only ever pulls low
   a_drive_low: assert property (bus_data_pin_oe_o |-> !bus_data_pin_o)
      else $error("data pin driven high");
   // No drive while the strap gives the pins away
   a_strap_gate: assert property (!bus_owns_pins_o |-> !bus_data_pin_oe_o)
      else $error("data pin driven with strap low");
   // Data drive only changes while the bus clock is low
   a_oe_clock_low: assert property ($changed(bus_data_pin_oe_o) |-> !bus_clock_pin_i)
      else $error("data drive changed with clock high");
   // Full reset request is a single pulse
   a_reset_single: assert property (power_reset_o |=> !power_reset_o)
      else $error("power reset pulse too long");
   // No second conversion start within the eight cycles after a pulse
   a_conv_spacing: assert property (begin_single_conversion_o |=> !begin_single_conversion_o [*8])
      else $error("conversion start repeated");
   // One byte decodes to at most one event
   a_one_event: assert property ($onehot0({power_reset_o, init_reset_o, start_continuous_o,
      begin_single_conversion_o, otp_wr_o}))
      else $error("several events at once");
   // Program-memory writes only with both enables set
   a_prog_gate: assert property (otp_wr_o |-> otp_access_en_o && otp_prog_en_o)
      else $error("program write without enables");
   // Watchdog setting only moves by bus command
   a_wd_bus: assert property ($changed(watchdog_en_o) |-> bus_owns_pins_o)
      else $error("watchdog changed without bus");
   // Main scenarios reached
   c_conv: cover property (begin_single_conversion_o);
   c_prog: cover property (otp_wr_o);
   c_ack: cover property ($rose(bus_data_pin_oe_o));
endmodule // ics_slave_assertions
bind ics_slave ics_slave_assertions u_chk (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_clock_pin_i(bus_clock_pin_i),
   .bus_data_pin_o(bus_data_pin_o), .bus_data_pin_oe_o(bus_data_pin_oe_o),
   .bus_owns_pins_o(bus_owns_pins_o), .watchdog_en_o(watchdog_en_o),
   .power_reset_o(power_reset_o), .init_reset_o(init_reset_o),
   .start_continuous_o(start_continuous_o),
   .begin_single_conversion_o(begin_single_conversion_o), .otp_wr_o(otp_wr_o),
   .otp_access_en_o(otp_access_en_o), .otp_prog_en_o(otp_prog_en_o)
);
`default_nettype wire

/* File: ics_master_model.sv */
// Bus master model driving the two-wire clock and data lines
`timescale 1ns/1ps
`default_nettype none
module ics_master_model (
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   // Both lines released at power-up
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Wait a number of system clocks
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // One bit slot: data set while clock low, read late in the high phase
   task automatic bit_slot(input logic b, output logic r);
      tick(2);
      sda_low_o <= ~b;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      r = sda_i;
      scl_o <= 1'b0;
   endtask
   // Start, also usable as repeated start
   task automatic start_cond();
      tick(2);
      sda_low_o <= 1'b0;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_low_o <= 1'b1;
      tick(4);
      scl_o <= 1'b0;
   endtask
   // Stop, then bus left idle with clock standing high
   task automatic stop_cond();
      tick(2);
      sda_low_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_low_o <= 1'b0;
      tick(8);
   endtask
   // Byte out MSB first, ack read in ninth slot
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
      bit_slot(1'b1, r);
      ack = ~r;
   endtask
   // Byte in; not acknowledging the last byte ends the read
   task automatic recv(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, r);
         b[i] = r;
      end
      bit_slot(last, r);
   endtask
endmodule // ics_master_model
`default_nettype wire

/* File: i2c_command_slave_bench.sv */
// Self-checking bench for the two-wire command slave
`timescale 1ns/1ps
`default_nettype none
module i2c_command_slave_bench;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic strap = 1'b1;
   logic user_prog = 1'b0;
   logic res_valid = 1'b0;
   logic [23:0] res_word = 24'h0;
   logic [23:0] wlat = 24'h0;
   wire [7:0] otp_rdata = wlat[7:0] ^ 8'hb4; // Program memory stand-in
   wire scl, sda_low, oe, owns, bus_o, wd, ref_on, ee_en, otp_en, prog_en;
   wire [4:0] ev;
   wire [15:0] otp_addr;
   wire [7:0] otp_wdata;
   wire sda_line = ~(sda_low | (oe & ~bus_o)); // Pull-up: released line reads high
   int pc [5] = '{0, 0, 0, 0, 0};
   int errors = 0;
   int tests_run = 0;
   // System clock
   always #50 clock_i = ~clock_i;
   // Count event pulses, latch program-memory write fields
   always @(posedge clock_i) begin
      for (int k = 0; k < 5; k++) pc[k] <= pc[k] + int'(ev[k]);
      if (ev[4]) wlat <= {otp_addr, otp_wdata};
   end
   ics_slave u_dut (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_clock_pin_i(scl),
      .bus_data_pin_i(sda_line), .bus_data_pin_o(bus_o), .bus_data_pin_oe_o(oe),
      .if_sel_strap_i(strap), .bus_owns_pins_o(owns), .user_prog_present_i(user_prog),
      .result_valid_i(res_valid), .main_bridge_result_i(res_word), .power_reset_o(ev[0]),
      .init_reset_o(ev[1]), .start_continuous_o(ev[2]), .begin_single_conversion_o(ev[3]),
      .watchdog_en_o(wd), .ee_ref_on_o(ref_on), .ee_access_en_o(ee_en),
      .otp_access_en_o(otp_en), .otp_prog_en_o(prog_en), .otp_wr_o(ev[4]),
      .otp_addr_o(otp_addr), .otp_wdata_o(otp_wdata), .otp_rdata_i(otp_rdata)
   );
   ics_master_model u_m (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
   // Compare and count
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Byte that must be acknowledged
   task automatic wb(input logic [7:0] b);
      logic a;
      u_m.send(b, a);
      chk(a, 1'b1);
   endtask
   // Write transfer: header, opcode, address bytes, data bytes, stop
   task automatic wrq(input logic [7:0] op, input logic [15:0] ad, input int na,
                      input logic [23:0] d, input int nd);
      u_m.start_cond();
      wb(8'h1f);
      wb(op);
      for (int i = na - 1; i >= 0; i--) wb(ad[8*i +: 8]);
      for (int i = nd - 1; i >= 0; i--) wb(d[8*i +: 8]);
      u_m.stop_cond();
   endtask
   task automatic cmd(input logic [7:0] op);
      wrq(op, 16'h0, 0, 24'h0, 0);
   endtask
   // Read transfer via repeated start, bytes collected MSB first
   task automatic rdq(input logic [7:0] op, input logic [15:0] ad, input int na,
                      input int nr, output logic [23:0] v);
      logic [7:0] b;
      v = 24'h0;
      u_m.start_cond();
      wb(8'h1f);
      wb(op);
      for (int i = na - 1; i >= 0; i--) wb(ad[8*i +: 8]);
      u_m.start_cond();
      wb(8'h1e);
      for (int i = 1; i <= nr; i++) begin
         u_m.recv(i == nr, b);
         v = {v[15:0], b};
      end
      u_m.stop_cond();
   endtask
   // Enable levels and pin ownership after reset
   task automatic t_reset();
      chk({wd, ref_on, ee_en, otp_en, prog_en, oe}, 6'h20);
      chk(owns, 1'b1);
   endtask
   // Foreign headers: no acknowledge, following command ignored
   task automatic t_addr();
      logic a;
      int n;
      n = pc[3];
      for (int j = 0; j < 3; j++) begin
         u_m.start_cond();
         u_m.send(8'h1d << j, a);
         chk(a, 1'b0);
         u_m.send(8'hce, a);
         chk(a, 1'b0);
         u_m.stop_cond();
      end
      chk(pc[3] - n, 0);
   endtask
   // Event commands pulse once; level commands clear and set one enable
   task automatic t_cmds();
      logic [7:0] evs [4] = '{8'hf0, 8'hc0, 8'hcc, 8'hce};
      logic [7:0] ops [10] = '{8'h9e, 8'h9f, 8'h86, 8'h87, 8'h90, 8'h91, 8'ha8, 8'ha9,
                               8'hac, 8'had};
      logic [4:0] lv;
      int n;
      for (int k = 0; k < 4; k++) begin
         n = pc[k];
         cmd(evs[k]);
         chk(pc[k] - n, 1);
      end
      for (int i = 0; i < 10; i++) begin
         cmd(ops[i]);
         lv = {wd, ref_on, ee_en, otp_en, prog_en};
         chk(lv[4 - i / 2], i % 2);
      end
   endtask
   // RAM word write and read back; result copy with and without program
   task automatic t_ram();
      logic [23:0] v;
      wrq(8'h00, 16'h9f, 1, 24'h5ac3e1, 3);
      rdq(8'h40, 16'h9f, 1, 3, v);
      chk(v, 24'h5ac3e1);
      for (int j = 0; j < 2; j++) begin
         user_prog <= j[0];
         res_word <= 24'h123456 + j;
         res_valid <= 1'b1;
         @(posedge clock_i);
         res_valid <= 1'b0;
         rdq(8'h40, 16'h0, 1, 3, v);
         chk(v, 24'h123456);
         rdq(8'h40, 16'hf4, 1, 3, v);
         chk(v, 24'h123456 + j);
      end
   endtask
   // User store: write, gated write, byte erase, block erase
   task automatic t_ee();
      logic [23:0] v;
      cmd(8'h87);
      cmd(8'h91);
      wrq(8'ha1, 16'h7f, 1, 24'h5a, 1);
      rdq(8'ha0, 16'h7f, 1, 2, v);
      chk(v, 24'h5a);
      cmd(8'h86);
      wrq(8'ha1, 16'h7f, 1, 24'h11, 1);
      cmd(8'h87);
      rdq(8'ha0, 16'h7f, 1, 2, v);
      chk(v, 24'h5a);
      wrq(8'ha2, 16'h7f, 1, 24'hff, 1);
      rdq(8'ha0, 16'h7f, 1, 2, v);
      chk(v, 24'h0);
      wrq(8'ha1, 16'h03, 1, 24'ha5, 1);
      wrq(8'ha4, 16'h7f, 1, 24'hff, 1);
      rdq(8'ha0, 16'h03, 1, 2, v);
      chk(v, 24'h0);
   endtask
   // Program memory: refused write, enabled write, read
   task automatic t_otp();
      logic [23:0] v;
      int n;
      n = pc[4];
      cmd(8'ha8);
      wrq(8'ha7, 16'h1234, 2, 24'h77, 1);
      chk(pc[4] - n, 0);
      cmd(8'ha9);
      cmd(8'had);
      wrq(8'ha7, 16'h1234, 2, 24'h77, 1);
      chk(pc[4] - n, 1);
      chk(wlat, 24'h123477);
      rdq(8'ha6, 16'h0040, 2, 1, v);
      chk(v, 24'hc3);
   endtask
   // Strap low releases the bus; high again restores it
   task automatic t_strap();
      logic a;
      strap <= 1'b0;
      u_m.tick(6);
      chk(owns, 1'b0);
      u_m.start_cond();
      u_m.send(8'h1f, a);
      chk(a, 1'b0);
      u_m.stop_cond();
      strap <= 1'b1;
      u_m.tick(6);
      cmd(8'h9e);
      chk(wd, 1'b0);
   endtask
   // Print counts and verdict, end the run
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence, with a second reset after the last test
   initial begin
      u_m.tick(8);
      sys_rst_i <= 1'b0;
      u_m.tick(6);
      t_reset();
      t_addr();
      t_cmds();
      t_ram();
      t_ee();
      t_otp();
      t_strap();
      sys_rst_i <= 1'b1;
      u_m.tick(2);
      sys_rst_i <= 1'b0;
      u_m.tick(6);
      t_reset();
      print_verdict();
   end
   // Hang guard
   initial begin
      #8000000;
      errors++;
      print_verdict();
   end
endmodule // i2c_command_slave_bench
`default_nettype wire
